// File: include/reset_clock_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef RESET_CLOCK_REGS_SVH
`define RESET_CLOCK_REGS_SVH

// ==================================================================
// Timing
`define CLK_PERIOD_NS     10
`define RESET_PULSE_NS    20000
// Least time, so round up to whole cycles
`define RESET_PULSE_CYC   ((`RESET_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HSE_STARTUP_CYC   1024

// ==================================================================
// Register byte offsets
`define CLK_CTRL_OFS      12'h000
`define CTRL_STS_OFS      12'h004
`define BD_CTRL_OFS       12'h008
`define INT_STS_OFS       12'h00c
`define INT_MSK_OFS       12'h010

// ==================================================================
// Field positions
`define CTRL_EN_BIT       0
`define CTRL_RDY_BIT      1
`define CTRL_BYP_BIT      2
`define CSR_CLR_BIT       24
`define CSR_FLAG_LSB      26
`define BD_DATA_LSB       0
`define BD_RST_BIT        16
`define INT_RDY_BIT       0
`define INT_LOST_BIT      1

// ==================================================================
// Reset values
`define BD_DATA_RST       8'h00
`define INT_MSK_RST       2'h0
`define FLAGS_RST         6'h00

`endif

// File: include/reset_clock_pkg.sv
// Types shared by the reset and fast oscillator front end
package reset_clock_pkg;

   // Internal system reset requests, one-cycle or level
   typedef struct packed {
      logic window_watchdog_expire;
      logic independent_watchdog_expire;
      logic sw_request;
      logic standby_entry;
      logic stop_entry;
   } reset_src_s;

   // Power reset requests
   typedef struct packed {
      logic power_on;
      logic power_down;
      logic standby_wakeup;
   } power_src_s;

   // Reset cause flags, msb first as they sit in the register
   typedef struct packed {
      logic lpwr;
      logic window_watchdog;
      logic independent_watchdog;
      logic sw;
      logic por;
      logic pin;
   } reset_flags_s;

   typedef enum logic [1:0] {RS_IDLE, RS_PULSE, RS_PIN} rst_state_e;
   typedef enum logic [1:0] {OSC_OFF, OSC_START, OSC_READY} osc_state_e;

endpackage : reset_clock_pkg

// File: design/reset_clock_front.sv
// Reset source gathering, reset pin stretcher and fast oscillator gating
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "reset_clock_regs.svh"

module reset_clock_front
   import reset_clock_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        external_reset_pin,
   input  wire logic        ce,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   input  wire reset_src_s  rst_src,
   input  wire logic        standby_reset_option,
   input  wire logic        stop_entry_reset_option,
   input  wire power_src_s  pwr_src,
   input  wire logic        external_reset_pin_in,
   output logic             external_reset_pin_out,
   output logic             external_reset_pin_oe_n,
   output logic             system_reset_n,
   output logic             power_reset_n,
   output logic             backup_reset_n,
   input  wire logic        oscillator_input_pin,
   output logic             osc_drive_en,
   output logic             osc_bypass,
   output logic             fast_external_clock
);

   // ===============================================================
   // Declarations
   rst_state_e   rst_state_reg;
   rst_state_e   rst_state_next;
   logic [11:0]  pulse_cnt_reg;
   logic         sys_rst_reg;
   logic         pin_oe_n_reg;
   logic         pwr_rst_n_reg;
   reset_flags_s flags_reg;
   reset_flags_s flags_set;
   logic         lp_evt;
   logic         pwr_evt;
   logic         int_evt;
   logic         ext_evt;

   logic         hse_en_reg;
   logic         hse_byp_reg;
   osc_state_e   osc_state_reg;
   logic [10:0]  start_cnt_reg;
   logic         hse_rdy;
   logic         rdy_rise;
   logic         rdy_lost;
   logic         drive_reg;
   logic         byp_out_reg;
   logic         clk_gate_reg;

   logic [7:0]   bd_data_reg;
   logic         bd_rst_bit_reg;
   logic         bd_rst_n_reg;

   logic [1:0]   int_sts_reg;
   logic [1:0]   int_msk_reg;
   logic [1:0]   int_evt_vec;
   logic         irq_reg;

   logic         pready_reg;
   logic         pslverr_reg;
   logic [31:0]  prdata_reg;
   logic         wr_take;
   logic [2:0]   wsel;
   logic         sw_ok;

   // ===============================================================
   // Register decode, shared by read and write paths
   function automatic logic [2:0] reg_sel(input logic [11:0] a);
      case (a)
         `CLK_CTRL_OFS: reg_sel = 3'h0;
         `CTRL_STS_OFS: reg_sel = 3'h1;
         `BD_CTRL_OFS:  reg_sel = 3'h2;
         `INT_STS_OFS:  reg_sel = 3'h3;
         `INT_MSK_OFS:  reg_sel = 3'h4;
         default:       reg_sel = 3'h7;
      endcase
   endfunction : reg_sel

   // ===============================================================
   // Reset sources
   // Low-power entry only resets when the option bit is cleared
   assign lp_evt  = (rst_src.standby_entry & ~standby_reset_option)
                  | (rst_src.stop_entry
                     & ~stop_entry_reset_option);
   assign pwr_evt = pwr_src.power_on | pwr_src.power_down
                  | pwr_src.standby_wakeup;
   assign int_evt = rst_src.window_watchdog_expire | rst_src.independent_watchdog_expire
                  | rst_src.sw_request | lp_evt | pwr_evt;
   assign ext_evt = ~external_reset_pin_in;

   // Cause bits to set this cycle
   always_comb
   begin
      flags_set      = `FLAGS_RST;
      flags_set.lpwr = lp_evt;
      flags_set.window_watchdog = rst_src.window_watchdog_expire;
      flags_set.independent_watchdog = rst_src.independent_watchdog_expire;
      flags_set.sw   = rst_src.sw_request;
      flags_set.por  = pwr_evt;
      // Pin flag only when nothing inside pulled the pin
      flags_set.pin  = ext_evt & ~int_evt & (rst_state_reg == RS_IDLE);
   end

   // Sequencer: stretch internal events, then wait for the pin to rise
   always_comb
   begin
      rst_state_next = rst_state_reg;
      case (rst_state_reg)
         RS_IDLE:
         begin
            if (int_evt)
               rst_state_next = RS_PULSE;
            else if (ext_evt)
               rst_state_next = RS_PIN;
         end
         RS_PULSE:
         begin
            if (pulse_cnt_reg == 12'(`RESET_PULSE_CYC - 1))
               rst_state_next = RS_PIN;
         end
         RS_PIN:
         begin
            // Pin may still be held low by the outside world
            if (!ext_evt)
               rst_state_next = RS_IDLE;
         end
         default: rst_state_next = RS_IDLE;
      endcase
   end

   // Sequencer state
   always_ff @(posedge clk)
   begin
      if (!external_reset_pin)
         rst_state_reg <= RS_IDLE;
      else if (ce)
         rst_state_reg <= rst_state_next;
   end

   // Pulse length counter, restarts with every new pulse
   always_ff @(posedge clk)
   begin
      if (!external_reset_pin)
         pulse_cnt_reg <= 12'h000;
      else if (ce)
      begin
         if (rst_state_reg == RS_PULSE)
            pulse_cnt_reg <= pulse_cnt_reg + 12'h001;
         else
            pulse_cnt_reg <= 12'h000;
      end
   end

   // Pin driver and reset outputs; open drain, so only the enable moves
   always_ff @(posedge clk)
   begin
      if (!external_reset_pin)
      begin
         pin_oe_n_reg  <= 1'b0;
         sys_rst_reg   <= 1'b1;
         pwr_rst_n_reg <= 1'b0;
      end
      else if (ce)
      begin
         pin_oe_n_reg  <= (rst_state_next != RS_PULSE);
         sys_rst_reg   <= (rst_state_next != RS_IDLE);
         pwr_rst_n_reg <= ~pwr_evt;
      end
   end

   // Cause flags survive system reset; power reset leaves por plus any cause set in the same cycle
   always_ff @(posedge clk)
   begin
      if (!external_reset_pin)
         flags_reg <= `FLAGS_RST;
      else if (ce)
      begin
         if (pwr_evt)
            flags_reg <= flags_set;
         else if (wr_take && wsel == 3'h1 && pwdata[`CSR_CLR_BIT])
            flags_reg <= flags_set;                                 // set wins
         else
            flags_reg <= flags_reg | flags_set;
      end
   end

   // ===============================================================
   // Fast external oscillator
   assign hse_rdy  = (osc_state_reg == OSC_READY);
   assign rdy_rise = (osc_state_reg == OSC_START) && hse_en_reg
                  && (start_cnt_reg == 11'(`HSE_STARTUP_CYC - 1));
   assign rdy_lost = hse_rdy && !hse_en_reg;

   // Control bits; bypass only changes while the oscillator is off
   always_ff @(posedge clk)
   begin
      if (!external_reset_pin || sys_rst_reg)
      begin
         hse_en_reg  <= 1'b0;
         hse_byp_reg <= 1'b0;
      end
      else if (ce && wr_take && wsel == 3'h0)
      begin
         hse_en_reg <= pwdata[`CTRL_EN_BIT];
         if (!hse_en_reg)
            hse_byp_reg <= pwdata[`CTRL_BYP_BIT];
      end
   end

   // Startup sequence; ready drops the cycle after enable is cleared
   always_ff @(posedge clk)
   begin
      if (!external_reset_pin || sys_rst_reg)
      begin
         osc_state_reg <= OSC_OFF;
         start_cnt_reg <= 11'h000;
      end
      else if (ce)
      begin
         case (osc_state_reg)
            OSC_OFF:
            begin
               start_cnt_reg <= 11'h000;
               if (hse_en_reg)
                  osc_state_reg <= OSC_START;
            end
            OSC_START:
            begin
               start_cnt_reg <= start_cnt_reg + 11'h001;
               if (!hse_en_reg)
                  osc_state_reg <= OSC_OFF;
               else if (rdy_rise)
                  osc_state_reg <= OSC_READY;
            end
            OSC_READY:
            begin
               if (!hse_en_reg)
                  osc_state_reg <= OSC_OFF;
            end
            default: osc_state_reg <= OSC_OFF;
         endcase
      end
   end

   // Pad controls and gated clock; the gate costs one cycle of latency
   always_ff @(posedge clk)
   begin
      if (!external_reset_pin || sys_rst_reg)
      begin
         drive_reg    <= 1'b0;
         byp_out_reg  <= 1'b0;
         clk_gate_reg <= 1'b0;
      end
      else if (ce)
      begin
         drive_reg    <= hse_en_reg & ~hse_byp_reg;
         byp_out_reg  <= hse_en_reg & hse_byp_reg;
         clk_gate_reg <= hse_rdy & hse_en_reg
                       & oscillator_input_pin;
      end
   end

   // ===============================================================
   // Backup area: cleared only by external_reset_pin or its own reset bit
   always_ff @(posedge clk)
   begin
      if (!external_reset_pin)
      begin
         bd_data_reg    <= `BD_DATA_RST;
         bd_rst_bit_reg <= 1'b0;
         bd_rst_n_reg   <= 1'b1;
      end
      else if (ce)
      begin
         bd_rst_n_reg <= ~bd_rst_bit_reg;
         if (wr_take && wsel == 3'h2)
            bd_rst_bit_reg <= pwdata[`BD_RST_BIT];
         // Held in reset while the bit is set, like the real domain
         if (bd_rst_bit_reg)
            bd_data_reg <= `BD_DATA_RST;
         else if (wr_take && wsel == 3'h2)
            bd_data_reg <= pwdata[`BD_DATA_LSB +: 8];
      end
   end

   // ===============================================================
   // Interrupts: sticky status, write one to clear, set wins
   assign int_evt_vec[`INT_RDY_BIT]  = rdy_rise;
   assign int_evt_vec[`INT_LOST_BIT] = rdy_lost;

   generate
      for (genvar i = 0; i < 2; i++)
      begin : g_sts
         always_ff @(posedge clk)
         begin
            if (!external_reset_pin || sys_rst_reg)
               int_sts_reg[i] <= 1'b0;
            else if (ce)
            begin
               if (int_evt_vec[i])
                  int_sts_reg[i] <= 1'b1;
               else if (wr_take && wsel == 3'h3 && pwdata[i])
                  int_sts_reg[i] <= 1'b0;
            end
         end
      end
   endgenerate

   // Mask and interrupt line
   always_ff @(posedge clk)
   begin
      if (!external_reset_pin || sys_rst_reg)
      begin
         int_msk_reg <= `INT_MSK_RST;
         irq_reg     <= 1'b0;
      end
      else if (ce)
      begin
         if (wr_take && wsel == 3'h4)
            int_msk_reg <= pwdata[1:0];
         irq_reg <= |(int_sts_reg & int_msk_reg);
      end
   end

   // ===============================================================
   // APB slave: one wait state, so every access takes three cycles
   assign wsel    = reg_sel(paddr);
   // Writes are dropped while the system is held in reset
   assign sw_ok   = ~sys_rst_reg;
   assign wr_take = psel & penable & pready_reg & pwrite & sw_ok;

   always_ff @(posedge clk)
   begin
      if (!external_reset_pin)
      begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
      end
      else if (ce)
      begin
         pready_reg  <= psel & penable & ~pready_reg;
         pslverr_reg <= psel & penable & ~pready_reg & (wsel == 3'h7);
         prdata_reg  <= 32'h0000_0000;
         if (psel && penable && !pready_reg && !pwrite)
         begin
            case (wsel)
               3'h0:
               begin
                  prdata_reg[`CTRL_EN_BIT]  <= hse_en_reg;
                  prdata_reg[`CTRL_RDY_BIT] <= hse_rdy;
                  prdata_reg[`CTRL_BYP_BIT] <= hse_byp_reg;
               end
               3'h1: prdata_reg[`CSR_FLAG_LSB +: 6] <= flags_reg;
               3'h2:
               begin
                  prdata_reg[`BD_DATA_LSB +: 8] <= bd_data_reg;
                  prdata_reg[`BD_RST_BIT]       <= bd_rst_bit_reg;
               end
               3'h3: prdata_reg[1:0] <= int_sts_reg;
               3'h4: prdata_reg[1:0] <= int_msk_reg;
               default: prdata_reg <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ===============================================================
   // Outputs, all but the tied-low pin output straight from flip-flops
   assign prdata                  = prdata_reg;
   assign pready                  = pready_reg;
   assign pslverr                 = pslverr_reg;
   assign irq                     = irq_reg;
   assign external_reset_pin_out  = 1'b0;  // Open drain, only ever pulls low
   assign external_reset_pin_oe_n = pin_oe_n_reg;
   assign system_reset_n          = ~sys_rst_reg;
   assign power_reset_n           = pwr_rst_n_reg;
   assign backup_reset_n          = bd_rst_n_reg;
   assign osc_drive_en            = drive_reg;
   assign osc_bypass              = byp_out_reg;
   assign fast_external_clock     = clk_gate_reg;

endmodule : reset_clock_front

// File: testbench/reset_clock_props.sv
// Port checker for the reset and fast oscillator front end
`timescale 1ns/1ps
`include "reset_clock_regs.svh"

// ==================================================================
// Checker
module reset_clock_props
   import reset_clock_pkg::*;
(
   input wire logic       clk,
   input wire logic       external_reset_pin,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pready,
   input wire logic       pslverr,
   input wire reset_src_s rst_src,
   input wire logic       standby_reset_option,
   input wire logic       stop_entry_reset_option,
   input wire power_src_s pwr_src,
   input wire logic       external_reset_pin_in,
   input wire logic       external_reset_pin_oe_n,
   input wire logic       system_reset_n,
   input wire logic       power_reset_n,
   input wire logic       osc_drive_en,
   input wire logic       osc_bypass,
   input wire logic       fast_external_clock
);
   localparam int PULSE = `RESET_PULSE_CYC;
   localparam int START = `HSE_STARTUP_CYC - 1;
   logic [11:0]   low_cnt;
   logic [11:0]   run_cnt;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!external_reset_pin);

   // Pin pulse length; parked at full in reset so the release edge passes
   always_ff @(posedge clk)
      if (!external_reset_pin)
         low_cnt <= 12'hfff;
      else if (external_reset_pin_oe_n)
         low_cnt <= 12'h000;
      else if (low_cnt != 12'hfff)
         low_cnt <= low_cnt + 12'h001;

   // Cycles the oscillator has been running, saturating
   always_ff @(posedge clk)
      if (!external_reset_pin || !(osc_drive_en || osc_bypass))
         run_cnt <= 12'h000;
      else if (run_cnt != 12'hfff)
         run_cnt <= run_cnt + 12'h001;

   sequence setup_s;
      psel && !penable;
   endsequence
   sequence access_s;
      psel && penable;
   endsequence

   // Bus answer timing
   bus_answer_a: assert property (setup_s ##1 access_s |=> pready)
      else $error("pready late");
   bus_pulse_a: assert property (pready |=> !pready)
      else $error("pready held");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr alone");
   // Reset sources
   sw_reset_a: assert property (
      rst_src.sw_request |-> ##[1:2] !system_reset_n)
      else $error("no reset on software request");
   lowpwr_reset_a: assert property (
      (rst_src.stop_entry && !stop_entry_reset_option)
      || (rst_src.standby_entry && !standby_reset_option)
      |-> ##[1:2] !system_reset_n)
      else $error("no reset on low-power entry");
   pin_reset_a: assert property (
      !external_reset_pin_in && external_reset_pin_oe_n
      |-> ##[1:2] !system_reset_n)
      else $error("no reset on pin low");
   power_reset_a: assert property (
      |pwr_src |=> !power_reset_n ##[0:1] !system_reset_n)
      else $error("no power reset");
   pin_held_a: assert property (
      !external_reset_pin_oe_n |-> !system_reset_n)
      else $error("pin driven outside reset");
   pulse_len_a: assert property (
      $rose(external_reset_pin_oe_n) |-> low_cnt >= PULSE)
      else $error("reset pulse short");
   // Oscillator gating
   clk_gated_a: assert property (
      fast_external_clock |-> run_cnt >= START)
      else $error("clock before ready");
   clk_stop_a: assert property (
      !(osc_drive_en || osc_bypass) |=> !fast_external_clock)
      else $error("clock after disable");
   osc_mode_a: assert property (
      !(osc_drive_en && osc_bypass))
      else $error("both oscillator modes");
endmodule : reset_clock_props

bind reset_clock_front reset_clock_props chk (.clk(clk), .external_reset_pin(external_reset_pin),
   .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
   .rst_src(rst_src), .standby_reset_option(standby_reset_option),
   .stop_entry_reset_option(stop_entry_reset_option), .pwr_src(pwr_src),
   .external_reset_pin_in(external_reset_pin_in),
   .external_reset_pin_oe_n(external_reset_pin_oe_n),
   .system_reset_n(system_reset_n), .power_reset_n(power_reset_n),
   .osc_drive_en(osc_drive_en), .osc_bypass(osc_bypass),
   .fast_external_clock(fast_external_clock));

// File: testbench/reset_osc_model.sv
// Reset pin with pull-up and the crystal or clock generator behind it
`timescale 1ns/1ps

// ==================================================================
// Pin and oscillator model
module reset_osc_model
(
   input  wire logic clk,
   input  wire logic pin_oe_n,
   input  wire logic pin_out,
   input  wire logic pull_low,
   input  wire logic drive_en,
   input  wire logic bypass_en,
   input  wire logic gen_on,
   output logic      pin_level,
   output logic      osc_level
);
   // Pull-up wins unless someone pulls the pin down
   assign pin_level = ((!pin_oe_n && !pin_out) || pull_low) ? 1'b0
                    : 1'b1;

   // A crystal swings only with its amplifier on; a stopped one sits low
   always_ff @(posedge clk)
      if ((drive_en && !bypass_en) || (bypass_en && gen_on))
         osc_level <= ~osc_level;
      else
         osc_level <= 1'b0;
endmodule : reset_osc_model

// File: testbench/tb_top.sv
// Self-checking bench for the reset and fast oscillator front end
`timescale 1ns/1ps
`include "reset_clock_regs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; \
   $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end

// ==================================================================
// Bench
module tb_top
   import reset_clock_pkg::*;
;
   logic        clk = 1'b0;
   logic        external_reset_pin = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   reset_src_s  rst_src = '0;
   logic        sb_opt = 1'b0;
   logic        st_opt = 1'b0;
   power_src_s  pwr_src = '0;
   logic        pin_level;
   logic        pin_out;
   logic        pin_oe_n;
   logic        sys_n;
   logic        pwr_n;
   logic        bkp_n;
   logic        osc_level;
   logic        drv_en;
   logic        byp;
   logic        fclk;
   logic        pull_low = 1'b0;
   logic        gen_on = 1'b0;
   logic [31:0] rd;
   logic        er;
   int          err_total = 0;
   int          checks = 0;
   int          cyc = 0;
   int          n;
   logic [4:0]  src_t [6] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h02};
   logic [31:0] flag_t [6] = '{32'h4000_0000, 32'h2000_0000, 32'h1000_0000,
                               32'h8000_0000, 32'h8000_0000, 32'h0};

   reset_clock_front uut (.clk(clk), .external_reset_pin(external_reset_pin), .ce(1'b1),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .rst_src(rst_src),
      .standby_reset_option(sb_opt), .stop_entry_reset_option(st_opt),
      .pwr_src(pwr_src), .external_reset_pin_in(pin_level),
      .external_reset_pin_out(pin_out), .external_reset_pin_oe_n(pin_oe_n),
      .system_reset_n(sys_n), .power_reset_n(pwr_n),
      .backup_reset_n(bkp_n), .oscillator_input_pin(osc_level),
      .osc_drive_en(drv_en), .osc_bypass(byp), .fast_external_clock(fclk));

   reset_osc_model partner (.clk(clk), .pin_oe_n(pin_oe_n),
      .pin_out(pin_out), .pull_low(pull_low), .drive_en(drv_en),
      .bypass_en(byp), .gen_on(gen_on), .pin_level(pin_level),
      .osc_level(osc_level));

   always #5 clk = ~clk;

   // Hang guard; the run needs about 17400 cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         err_total++;
         results();
      end
   end

   task automatic results;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : results

   // One APB transfer; an idle edge at the end keeps drivers single per step
   task automatic apb(input logic [11:0] a, input logic w,
                      input logic [31:0] d);
      psel    <= 1'b1;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rd      = prdata;
      er      = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask : wr

   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      apb(a, 1'b0, 32'h0);
      `CHK(rd, e)
   endtask : rdchk

   // Waits for a system reset to start, then measures how long it lasts
   task automatic rst_len(output int k);
      repeat (20)
         if (sys_n !== 1'b0)
            @(posedge clk);
      for (k = 0; sys_n === 1'b0; k++)
         @(posedge clk);
      @(posedge clk);
   endtask : rst_len

   // Main sequence
   initial
   begin
      repeat (12) @(posedge clk);
      external_reset_pin <= 1'b1;
      for (n = 0; sys_n !== 1'b1 && n < 3000; n++)
         @(posedge clk);
      repeat (2) @(posedge clk);
      wr(`CTRL_STS_OFS, 32'h0100_0000);
      wr(`BD_CTRL_OFS, 32'h0000_005a);
      // Internal sources in turn; the last one has its option set
      for (int i = 0; i < 6; i++)
      begin
         wr(`CLK_CTRL_OFS, 32'h1);
         sb_opt  <= (i == 5);
         rst_src <= reset_src_s'(src_t[i]);
         @(posedge clk);
         rst_src <= '0;
         rst_len(n);
         `CHK(n >= `RESET_PULSE_CYC, i < 5)
         rdchk(`CTRL_STS_OFS, flag_t[i]);
         rdchk(`CLK_CTRL_OFS, {31'h0, i == 5});
         rdchk(`BD_CTRL_OFS, 32'h5a);
         wr(`CTRL_STS_OFS, 32'h0100_0000);
      end
      $display("done: internal sources");
      // External party pulls the pin
      pull_low <= 1'b1;
      repeat (40) @(posedge clk);
      `CHK(sys_n, 1'b0)
      pull_low <= 1'b0;
      rst_len(n);
      rdchk(`CTRL_STS_OFS, 32'h0400_0000);
      $display("done: pin reset");
      // Each power reset source
      for (int j = 0; j < 3; j++)
      begin
         pwr_src <= power_src_s'(3'h4 >> j);
         @(posedge clk);
         pwr_src <= '0;
         @(posedge clk);
         `CHK(pwr_n, 1'b0)
         rst_len(n);
         rdchk(`CTRL_STS_OFS, 32'h0800_0000);
         rdchk(`BD_CTRL_OFS, 32'h5a);
      end
      $display("done: power reset");
      // Backup reset leaves the clock control alone
      wr(`CLK_CTRL_OFS, 32'h1);
      wr(`BD_CTRL_OFS, 32'h0001_005a);
      rdchk(`BD_CTRL_OFS, 32'h0001_0000);
      `CHK(bkp_n, 1'b0)
      apb(`CLK_CTRL_OFS, 1'b0, 32'h0);
      `CHK(rd[0], 1'b1)
      wr(`BD_CTRL_OFS, 32'h0);
      rdchk(`BD_CTRL_OFS, 32'h0);
      wr(`CLK_CTRL_OFS, 32'h0);
      wr(`INT_STS_OFS, 32'h3);
      $display("done: backup reset");
      // Crystal start-up, masked then unmasked interrupt
      wr(`CLK_CTRL_OFS, 32'h1);
      // Pad controls register one edge after the enable bit lands
      @(posedge clk);
      `CHK({drv_en, byp}, 2'b10)
      for (n = 0; fclk !== 1'b1 && n < 2000; n++)
         @(posedge clk);
      `CHK(n > 1010 && n < 1040, 1'b1)
      `CHK(irq, 1'b0)
      rdchk(`CLK_CTRL_OFS, 32'h3);
      wr(`INT_MSK_OFS, 32'h1);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b1)
      wr(`INT_STS_OFS, 32'h1);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b0)
      wr(`CLK_CTRL_OFS, 32'h0);
      repeat (2) @(posedge clk);
      `CHK({fclk, drv_en}, 2'b00)
      rdchk(`CLK_CTRL_OFS, 32'h0);
      rdchk(`INT_STS_OFS, 32'h2);
      $display("done: crystal");
      // Bypass mode; the bypass bit is frozen while enabled
      gen_on <= 1'b1;
      wr(`CLK_CTRL_OFS, 32'h4);
      wr(`CLK_CTRL_OFS, 32'h5);
      @(posedge clk);
      `CHK({drv_en, byp}, 2'b01)
      wr(`CLK_CTRL_OFS, 32'h1);
      rdchk(`CLK_CTRL_OFS, 32'h5);
      wr(`CLK_CTRL_OFS, 32'h0);
      $display("done: bypass");
      // Unmapped place
      apb(12'h100, 1'b0, 32'h0);
      `CHK({er, rd}, {1'b1, 32'h0})
      $display("done: unmapped");
      results();
   end
endmodule : tb_top
